// ### logic/hthf_pkg.sv
// constants and register map for the host task handshake flag block
// Summary of operation
// - status flags driven only in run mode
// - module reset drops access flag until ready
// - host access inside grace time is not errored
// - program error sets flag, lamp, stores line/code
// - program error drops access flag
// - system failure sets flag, lamp, stores code
// - system failure drops access flag
// - alive flag low in reset processing
// - host general outputs readable by software
// - select bit is general output unless host-triggered
// - launch edge starts every selected task
// - launch ignored for busy or starting task
// - select rising under held strobe starts nothing
// - launch acts only while access flag high
// - strobe never general; compiled tasks never launched
// - select ignored unless task is host-triggered
// - reset request acts after 200/2000 ms grace
// - start condition defaults to boot (preloaded) for both tasks
// - disabled task never loaded or started
// - access flag rises once multitask possible
// - 26 software-driven general inputs toward host
// - host access when not enabled gives unit-down error
package hthf_pkg;

	// register byte addresses
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_EVENT   = 5'h04;
	localparam logic [4:0] REG_STATUS  = 5'h08;
	localparam logic [4:0] REG_GPIN    = 5'h0C;
	localparam logic [4:0] REG_GPOUT   = 5'h10;
	localparam logic [4:0] REG_TASKCFG = 5'h14;
	localparam logic [4:0] REG_ERRINFO = 5'h18;

	// control register fields
	localparam int CTRL_GRACE_LONG = 0;
	localparam int CTRL_COMPILED   = 4;

	// event register fields (write one to fire)
	localparam int EV_MT_READY = 0;
	localparam int EV_PROG_ERR = 1;
	localparam int EV_SYS_FAIL = 2;
	localparam int EV_TASK_END = 4;

	// task start condition field, three bits per task
	localparam int          TC_W     = 3;
	localparam logic [2:0]  TC_START = 3'h0;
	localparam logic [2:0]  TC_IT    = 3'h1;
	localparam logic [2:0]  TC_BOOT  = 3'h2;
	localparam logic [2:0]  TC_ON    = 3'h3;
	localparam logic [2:0]  TC_OFF   = 3'h4;
	localparam logic [31:0] TASKCFG_RST = {26'h0, TC_BOOT, TC_BOOT};

	// pin group widths and reset values
	localparam int          NUM_TASKS = 2;
	localparam int          GPOUT_W   = 23;
	localparam int          GPIN_W    = 26;
	localparam logic [31:0] CTRL_RST  = 32'h00000000;
	localparam logic [31:0] ERR_RST   = 32'h00000000;

	// error record location in buffer memory
	localparam logic [15:0] ERR_BUF_BASE = 16'h2400;

	// mode switch: run mode is setting 0 or 1
	localparam logic [3:0] MODE_RUN_MAX = 4'h1;

	// timing
	localparam int CLK_MHZ        = 250;
	localparam int GRACE_SHORT_MS = 200;
	localparam int GRACE_LONG_MS  = 2000;
	localparam int GRACE_SHORT_CYC = GRACE_SHORT_MS * 1000 * CLK_MHZ;
	localparam int GRACE_LONG_CYC  = GRACE_LONG_MS * 1000 * CLK_MHZ;
	localparam int RST_PROC_CYC    = 16;

	typedef enum logic [1:0] {RS_IDLE, RS_GRACE, RS_PROC} hthf_rst_state_t;

endpackage : hthf_pkg

// ### logic/hthf_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module hthf_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// pins in, synchronised out
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] meta;

	initial
	begin
		if (W < 1) $error("hthf_sync: width must be at least one");
	end

	// first stage is read by the second stage only
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta     <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta     <= pin_in;
			sync_out <= meta;
		end
	end

endmodule : hthf_sync
`default_nettype wire

// ### logic/hthf_launch.sv
// per-task launch by host strobe edge with busy tracking
`timescale 1ns/10ps
`default_nettype none
module hthf_launch #(
	parameter int N = 2
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// launch conditions
	input  wire logic         strobe_rise,
	input  wire logic         access_ok,
	input  wire logic [N-1:0] select,
	input  wire logic [N-1:0] host_triggered,
	input  wire logic [N-1:0] compiled,
	// task life cycle
	input  wire logic [N-1:0] task_end,
	input  wire logic         module_reset,
	output var  logic [N-1:0] busy,
	output var  logic [N-1:0] start_pulse
);

	initial
	begin
		if (N < 1) $error("hthf_launch: need at least one task");
	end

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_task
			logic go;
			// edge only, so a select raised under a held strobe does nothing
			assign go = strobe_rise && access_ok && select[i]
				&& host_triggered[i] && !compiled[i]
				&& !busy[i];

			// busy from launch until software reports the task ended or a module reset clears it
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					busy[i]        <= 1'b0;
					start_pulse[i] <= 1'b0;
				end
				else
				begin
					start_pulse[i] <= go && !module_reset;
					if (module_reset)
						busy[i] <= 1'b0;
					else if (go)
						busy[i] <= 1'b1;
					else if (task_end[i])
						busy[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : hthf_launch
`default_nettype wire

// ### logic/hthf_top.sv
// host task handshake flags with avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none
module hthf_top #(
	parameter int unsigned GRACE_SHORT_CYC = hthf_pkg::GRACE_SHORT_CYC,
	parameter int unsigned GRACE_LONG_CYC  = hthf_pkg::GRACE_LONG_CYC,
	parameter int unsigned RST_PROC_CYC    = hthf_pkg::RST_PROC_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// avalon-mm slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output logic             waitrequest,
	// mode switch pins
	input  wire logic [3:0]  mode_switch,
	// host-driven pins
	input  wire logic [22:0] host_gp_out,
	input  wire logic        task1_select,
	input  wire logic        task2_select,
	input  wire logic        task_launch_strobe,
	input  wire logic        module_reset_request,
	input  wire logic        host_buffer_rw_cmd,
	// flags toward host
	output var  logic        access_permitted_flag,
	output var  logic        program_error_flag,
	output var  logic        system_failure_flag,
	output var  logic        module_alive_flag,
	output var  logic [25:0] host_gp_in,
	output var  logic        unit_down_error,
	// module side
	output var  logic        fault_lamp,
	output var  logic        module_reset_active,
	output var  logic [1:0]  task_start,
	output var  logic [1:0]  task_load_req,
	// error record writes into buffer memory
	output var  logic        err_buf_we,
	output var  logic [15:0] err_buf_addr,
	output var  logic [15:0] err_buf_data
);

	initial
	begin
		if (GRACE_SHORT_CYC < 1 || GRACE_LONG_CYC < 1 || RST_PROC_CYC < 1)
			$error("hthf_top: timing counts must be at least one");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [22:0] gp_out_s;
	logic [1:0]  sel_s;
	logic        strobe_s;
	logic        rst_req_s;
	logic        rw_cmd_s;
	logic [3:0]  mode_s;

	// every host pin comes from another domain
	hthf_sync #(.W(32)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.pin_in   ({mode_switch, host_buffer_rw_cmd, module_reset_request,
		            task_launch_strobe, task2_select, task1_select, host_gp_out}),
		.sync_out ({mode_s, rw_cmd_s, rst_req_s, strobe_s, sel_s, gp_out_s})
	);

	// previous samples for edge detection
	logic strobe_q;
	logic rst_req_q;
	logic rw_cmd_q;
	logic strobe_rise;
	logic rst_req_rise;
	logic rw_cmd_rise;
	logic run_mode;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			strobe_q  <= 1'b0;
			rst_req_q <= 1'b0;
			rw_cmd_q  <= 1'b0;
		end
		else
		begin
			strobe_q  <= strobe_s;
			rst_req_q <= rst_req_s;
			rw_cmd_q  <= rw_cmd_s;
		end
	end

	assign strobe_rise  = strobe_s && !strobe_q;
	assign rst_req_rise = rst_req_s && !rst_req_q;
	assign rw_cmd_rise  = rw_cmd_s && !rw_cmd_q;
	assign run_mode     = (mode_s <= hthf_pkg::MODE_RUN_MAX);

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic        served;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] wmask;
	logic [31:0] ctrl;
	logic [31:0] gpin;
	logic [31:0] taskcfg;
	logic [31:0] errinfo;
	logic [31:0] ev;
	logic [31:0] status;
	logic [31:0] gpout_view;

	// every access takes two cycles: taken, then answered
	assign waitrequest = (read || write) && !served;
	assign wr_go       = write && served;
	assign rd_go       = read && !served;
	assign wmask       = {{8{byteenable[3]}}, {8{byteenable[2]}},
	                      {8{byteenable[1]}}, {8{byteenable[0]}}};
	assign ev          = (wr_go && address == hthf_pkg::REG_EVENT) ? (writedata & wmask) : 32'h00000000;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			served <= 1'b0;
		else
			served <= (read || write) && !served;
	end

	// software-written registers honour byte enables
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl    <= hthf_pkg::CTRL_RST;
			gpin    <= 32'h00000000;
			taskcfg <= hthf_pkg::TASKCFG_RST;
			errinfo <= hthf_pkg::ERR_RST;
		end
		else if (wr_go)
		begin
			case (address)
				hthf_pkg::REG_CTRL:    ctrl    <= (ctrl & ~wmask) | (writedata & wmask);
				hthf_pkg::REG_GPIN:    gpin    <= (gpin & ~wmask) | (writedata & wmask);
				hthf_pkg::REG_TASKCFG: taskcfg <= (taskcfg & ~wmask) | (writedata & wmask);
				hthf_pkg::REG_ERRINFO: errinfo <= (errinfo & ~wmask) | (writedata & wmask);
				default: ;
			endcase
		end
	end

	// read data set at the taking edge, stands while waitrequest is low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			readdata <= 32'h00000000;
		else if (rd_go)
		begin
			case (address)
				hthf_pkg::REG_CTRL:    readdata <= ctrl;
				hthf_pkg::REG_STATUS:  readdata <= status;
				hthf_pkg::REG_GPIN:    readdata <= gpin;
				hthf_pkg::REG_GPOUT:   readdata <= gpout_view;
				hthf_pkg::REG_TASKCFG: readdata <= taskcfg;
				hthf_pkg::REG_ERRINFO: readdata <= errinfo;
				default:               readdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// task start conditions

	logic [1:0] cond_it;
	logic [1:0] loadable;
	logic [2:0] cond_t1;
	logic [2:0] cond_t2;

	assign cond_t1     = taskcfg[2:0];
	assign cond_t2     = taskcfg[5:3];
	assign cond_it     = {cond_t2 == hthf_pkg::TC_IT, cond_t1 == hthf_pkg::TC_IT};
	// on-demand and disabled tasks are not preloaded
	assign loadable[0] = (cond_t1 != hthf_pkg::TC_OFF) && (cond_t1 != hthf_pkg::TC_ON);
	assign loadable[1] = (cond_t2 != hthf_pkg::TC_OFF) && (cond_t2 != hthf_pkg::TC_ON);

	// a select bit of a non-host-triggered task reads as a plain output
	assign gpout_view = {7'h00, sel_s & ~cond_it, gp_out_s};

	////////////////////////////////////////////////////////////////////////
	// module reset sequence: grace time, then reset processing

	hthf_pkg::hthf_rst_state_t rst_state;
	logic [31:0] rst_cnt;
	logic [31:0] grace_last;
	logic        in_grace;
	logic        mod_rst;
	logic        proc_done;

	assign grace_last = ctrl[hthf_pkg::CTRL_GRACE_LONG] ? (GRACE_LONG_CYC - 32'd1) : (GRACE_SHORT_CYC - 32'd1);
	assign in_grace   = (rst_state == hthf_pkg::RS_GRACE);
	assign mod_rst    = (rst_state == hthf_pkg::RS_PROC);
	assign proc_done  = mod_rst && (rst_cnt == RST_PROC_CYC - 32'd1);

	// power-up enters reset processing too, so the alive flag starts low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rst_state <= hthf_pkg::RS_PROC;
			rst_cnt   <= 32'h00000000;
		end
		else
		begin
			case (rst_state)
				hthf_pkg::RS_IDLE:
				begin
					rst_cnt <= 32'h00000000;
					if (rst_req_rise)
						rst_state <= hthf_pkg::RS_GRACE;
				end
				hthf_pkg::RS_GRACE:
				begin
					// host accesses still served during this wait
					if (rst_cnt >= grace_last)
					begin
						rst_state <= hthf_pkg::RS_PROC;
						rst_cnt   <= 32'h00000000;
					end
					else
						rst_cnt <= rst_cnt + 32'd1;
				end
				hthf_pkg::RS_PROC:
				begin
					if (proc_done)
					begin
						rst_state <= hthf_pkg::RS_IDLE;
						rst_cnt   <= 32'h00000000;
					end
					else
						rst_cnt <= rst_cnt + 32'd1;
				end
				default:
				begin
					rst_state <= hthf_pkg::RS_IDLE;
					rst_cnt   <= 32'h00000000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// multitask and error state

	logic mt_ready;
	logic prog_err;
	logic sys_fail;
	logic mt_enabled;

	// ready comes from software once tasks can run; errors end it
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mt_ready <= 1'b0;
		else if (mod_rst)
			mt_ready <= 1'b0;
		else if ((ev[hthf_pkg::EV_PROG_ERR] || ev[hthf_pkg::EV_SYS_FAIL]) && mt_ready)
			mt_ready <= 1'b0;
		else if (ev[hthf_pkg::EV_MT_READY] && !prog_err && !sys_fail)
			mt_ready <= 1'b1;
	end

	// errors count only during multitask execution; cleared by module reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			prog_err <= 1'b0;
			sys_fail <= 1'b0;
		end
		else if (mod_rst)
		begin
			prog_err <= 1'b0;
			sys_fail <= 1'b0;
		end
		else
		begin
			if (ev[hthf_pkg::EV_PROG_ERR] && mt_ready)
				prog_err <= 1'b1;
			if (ev[hthf_pkg::EV_SYS_FAIL] && mt_ready)
				sys_fail <= 1'b1;
		end
	end

	assign mt_enabled = mt_ready && !mod_rst;

	////////////////////////////////////////////////////////////////////////
	// error record written into buffer memory

	logic err_second;

	// program error stores line then code; system failure stores code only
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			err_buf_we   <= 1'b0;
			err_buf_addr <= 16'h0000;
			err_buf_data <= 16'h0000;
			err_second   <= 1'b0;
		end
		else if (ev[hthf_pkg::EV_PROG_ERR] && mt_ready && !mod_rst)
		begin
			err_buf_we   <= 1'b1;
			err_buf_addr <= hthf_pkg::ERR_BUF_BASE;
			err_buf_data <= errinfo[15:0];
			err_second   <= 1'b1;
		end
		else if (err_second)
		begin
			err_buf_we   <= 1'b1;
			err_buf_addr <= hthf_pkg::ERR_BUF_BASE + 16'h0001;
			err_buf_data <= errinfo[31:16];
			err_second   <= 1'b0;
		end
		else if (ev[hthf_pkg::EV_SYS_FAIL] && mt_ready && !mod_rst)
		begin
			err_buf_we   <= 1'b1;
			err_buf_addr <= hthf_pkg::ERR_BUF_BASE;
			err_buf_data <= errinfo[31:16];
		end
		else
			err_buf_we <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// task launch

	logic [1:0] busy;
	logic [1:0] start_p;

	hthf_launch #(.N(hthf_pkg::NUM_TASKS)) u_launch (
		.clk            (clk),
		.reset          (reset),
		.strobe_rise    (strobe_rise),
		.access_ok      (access_permitted_flag),
		.select         (sel_s),
		.host_triggered (cond_it),
		.compiled       (ctrl[hthf_pkg::CTRL_COMPILED +: 2]),
		.task_end       (ev[hthf_pkg::EV_TASK_END +: 2]),
		.module_reset   (mod_rst),
		.busy           (busy),
		.start_pulse    (start_p)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs toward host and module

	// outside run mode the three handshake flags stay low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			access_permitted_flag <= 1'b0;
			program_error_flag    <= 1'b0;
			system_failure_flag   <= 1'b0;
			module_alive_flag     <= 1'b0;
			fault_lamp            <= 1'b0;
			module_reset_active   <= 1'b0;
		end
		else
		begin
			access_permitted_flag <= run_mode && mt_enabled && !prog_err && !sys_fail;
			program_error_flag    <= run_mode && prog_err;
			system_failure_flag   <= run_mode && sys_fail;
			module_alive_flag     <= !mod_rst;
			fault_lamp            <= prog_err || sys_fail;
			module_reset_active   <= mod_rst;
		end
	end

	// unit-down error, except inside the grace window after a reset request
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			unit_down_error <= 1'b0;
		else
			unit_down_error <= rw_cmd_rise && !mt_enabled && !in_grace;
	end

	// general inputs, launches and preload requests
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			host_gp_in    <= 26'h0000000;
			task_start    <= 2'h0;
			task_load_req <= 2'h0;
		end
		else
		begin
			host_gp_in    <= gpin[25:0];
			task_start    <= start_p;
			task_load_req <= proc_done ? loadable : 2'h0;
		end
	end

	// status word shows the block's own state
	assign status = {16'h0000, 2'h0, busy, mode_s, 1'b0, in_grace, mod_rst, run_mode,
	                 module_alive_flag, system_failure_flag, program_error_flag, access_permitted_flag};

endmodule : hthf_top
`default_nettype wire

// ### verif/hthf_properties.sv
// concurrent checks on the flag, launch and error record outputs
`timescale 1ns/10ps
`default_nettype none
module hthf_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// observed pins
	input wire logic [3:0]  mode_switch,
	input wire logic        access_permitted_flag,
	input wire logic        program_error_flag,
	input wire logic        system_failure_flag,
	input wire logic        module_alive_flag,
	input wire logic        unit_down_error,
	input wire logic        fault_lamp,
	input wire logic        module_reset_active,
	input wire logic [1:0]  task_start,
	input wire logic [1:0]  task_load_req,
	input wire logic        err_buf_we,
	input wire logic [15:0] err_buf_addr
);
	// single domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// five cycles cover two sync stages plus the flag flop
	property p_run_gate;
		(mode_switch > hthf_pkg::MODE_RUN_MAX) [*5] |->
			!(access_permitted_flag | program_error_flag | system_failure_flag);
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("status flag driven outside run mode");
	property p_perr_access;
		program_error_flag |-> !access_permitted_flag;
	endproperty
	a_perr_access: assert property (p_perr_access) else $error("access high with program error");
	property p_sfail_access;
		system_failure_flag |-> !access_permitted_flag;
	endproperty
	a_sfail_access: assert property (p_sfail_access) else $error("access high with system failure");
	property p_lamp;
		program_error_flag || system_failure_flag |-> fault_lamp;
	endproperty
	a_lamp: assert property (p_lamp) else $error("fault lamp dark during error");
	property p_proc;
		module_reset_active |-> !module_alive_flag && !access_permitted_flag;
	endproperty
	a_proc: assert property (p_proc) else $error("alive or access high in reset processing");
	property p_start_access;
		|task_start |-> $past(access_permitted_flag, 2);
	endproperty
	a_start_access: assert property (p_start_access) else $error("task started without access");
	property p_start_once;
		task_start[0] |=> !task_start[0];
	endproperty
	a_start_once: assert property (p_start_once) else $error("task start repeated");
	property p_err_first;
		err_buf_we && !$past(err_buf_we) |-> err_buf_addr == hthf_pkg::ERR_BUF_BASE;
	endproperty
	a_err_first: assert property (p_err_first) else $error("error record not at base");
	property p_err_second;
		err_buf_we && $past(err_buf_we) |-> err_buf_addr == hthf_pkg::ERR_BUF_BASE + 16'h0001;
	endproperty
	a_err_second: assert property (p_err_second) else $error("error code word misplaced");
	property p_ud_pulse;
		unit_down_error |=> !unit_down_error;
	endproperty
	a_ud_pulse: assert property (p_ud_pulse) else $error("unit down error longer than a cycle");
	property p_load_alive;
		|task_load_req |=> $rose(module_alive_flag);
	endproperty
	a_load_alive: assert property (p_load_alive) else $error("program load apart from alive rise");
endmodule : hthf_props
bind hthf_top hthf_props u_props (.clk(clk), .reset(reset), .mode_switch(mode_switch),
	.access_permitted_flag(access_permitted_flag), .program_error_flag(program_error_flag),
	.system_failure_flag(system_failure_flag), .module_alive_flag(module_alive_flag),
	.unit_down_error(unit_down_error), .fault_lamp(fault_lamp), .module_reset_active(module_reset_active),
	.task_start(task_start), .task_load_req(task_load_req), .err_buf_we(err_buf_we), .err_buf_addr(err_buf_addr));
`default_nettype wire

// ### verif/hthf_host_model.sv
// controller host model driving the handshake pins
`timescale 1ns/10ps
`default_nettype none
module hthf_host_model (
	// clock and status from the module
	input  wire logic        clk,
	input  wire logic        module_alive_flag,
	// host-driven pins
	output var  logic [22:0] host_gp_out,
	output var  logic        task1_select,
	output var  logic        task2_select,
	output var  logic        task_launch_strobe,
	output var  logic        module_reset_request,
	output var  logic        host_buffer_rw_cmd
);
	// all pins idle at time zero
	initial
	begin
		host_gp_out = 23'h000000;
		{task1_select, task2_select, task_launch_strobe} = 3'h0;
		{module_reset_request, host_buffer_rw_cmd} = 2'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic set_pins(input logic [22:0] gp, input logic [1:0] sel);
		host_gp_out <= gp;
		task1_select <= sel[0];
		task2_select <= sel[1];
		tick(1);
	endtask : set_pins
	// late puts the selects up only after the strobe is already high
	task automatic launch(input logic [1:0] sel, input logic late);
		if (!late)
			set_pins(host_gp_out, sel);
		task_launch_strobe <= 1'b1;
		tick(4);
		if (late)
			set_pins(host_gp_out, sel);
		tick(6);
		task_launch_strobe <= 1'b0;
		tick(2);
		set_pins(host_gp_out, 2'b00);
		tick(2);
	endtask : launch
	// held three cycles so the two sync stages see it
	task automatic reset_req;
		module_reset_request <= 1'b1;
		tick(3);
		module_reset_request <= 1'b0;
		tick(3);
	endtask : reset_req
	// no buffer access while the module is down
	task automatic rw_cmd;
		if (module_alive_flag === 1'b1)
		begin
			host_buffer_rw_cmd <= 1'b1;
			tick(3);
			host_buffer_rw_cmd <= 1'b0;
			tick(3);
		end
	endtask : rw_cmd
endmodule : hthf_host_model
`default_nettype wire

// ### verif/tb_host_task_handshake_flags.sv
// self-checking bench for the host task handshake flag block
`timescale 1ns/10ps
`default_nettype none
module tb_host_task_handshake_flags;
	logic        clk, reset, read, write, waitrequest, task1_select, task2_select, task_launch_strobe;
	logic        module_reset_request, host_buffer_rw_cmd, access_permitted_flag, program_error_flag;
	logic        system_failure_flag, module_alive_flag, unit_down_error, fault_lamp, module_reset_active;
	logic        err_buf_we;
	logic [4:0]  address;
	logic [3:0]  mode_switch;
	logic [31:0] writedata, readdata, q;
	logic [22:0] host_gp_out;
	logic [25:0] host_gp_in;
	logic [1:0]  task_start, task_load_req;
	logic [15:0] err_buf_addr, err_buf_data;
	logic [15:0] eb_a[4], eb_d[4];
	int          fail_count = 0, n_checks = 0, cyc = 0, n_ud = 0, eb_n = 0;
	int          n_st[2] = '{0, 0}, n_ld[2] = '{0, 0};
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
	////////////////////////////////////////
	// short grace counts keep the run brief
	hthf_top #(.GRACE_SHORT_CYC(20), .GRACE_LONG_CYC(40)) DUT (.*, .byteenable(4'hF));
	hthf_host_model host (.*);
	////////////////////////////////////////
	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// pulses counted on the falling edge, away from the bench's own edge
	always @(negedge clk)
	begin
		n_st[0] += int'(task_start[0] === 1'b1);
		n_st[1] += int'(task_start[1] === 1'b1);
		n_ld[0] += int'(task_load_req[0] === 1'b1);
		n_ld[1] += int'(task_load_req[1] === 1'b1);
		n_ud += int'(unit_down_error === 1'b1);
		if (err_buf_we === 1'b1)
		begin
			eb_a[eb_n % 4] = err_buf_addr;
			eb_d[eb_n % 4] = err_buf_data;
			eb_n++;
		end
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			finish_test();
		end
	end
	////////////////////////////////////////
	task automatic finish_test;
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// one avalon access; the spare edge keeps strobes from being reassigned in one step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		tick(1);
	endtask : bus
	task automatic wait_alive(input logic v);
		for (int i = 0; i < 40 && module_alive_flag !== v; i++)
			tick(1);
	endtask : wait_alive
	////////////////////////////////////////
	task automatic t_boot;
		`CHK(module_alive_flag, 1'b0)
		wait_alive(1'b1);
		`CHK(n_ld[0] + n_ld[1], 2)
		bus(1'b0, hthf_pkg::REG_TASKCFG, 32'h0);
		`CHK(q, hthf_pkg::TASKCFG_RST)
		bus(1'b0, 5'h1C, 32'h0);
		`CHK(q, 32'h00000000)
		`CHK(access_permitted_flag, 1'b0)
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000001);
		tick(3);
		`CHK(access_permitted_flag, 1'b1)
	endtask : t_boot
	task automatic t_gp;
		host.set_pins(23'h5A5A5A, 2'b10);
		tick(3);
		bus(1'b0, hthf_pkg::REG_GPOUT, 32'h0);
		`CHK(q[22:0], 23'h5A5A5A)
		`CHK(q[24:23], 2'b10)
		host.set_pins(23'h000000, 2'b00);
		bus(1'b1, hthf_pkg::REG_GPIN, 32'h02AAAAAA);
		tick(2);
		`CHK(host_gp_in, 26'h2AAAAAA)
	endtask : t_gp
	task automatic t_launch;
		int s0, s1;
		bus(1'b1, hthf_pkg::REG_TASKCFG, {26'h0, hthf_pkg::TC_IT, hthf_pkg::TC_IT});
		s0 = n_st[0];
		s1 = n_st[1];
		host.launch(2'b11, 1'b0);
		`CHK(n_st[0] - s0, 1)
		`CHK(n_st[1] - s1, 1)
		host.launch(2'b01, 1'b0);
		`CHK(n_st[0] - s0, 1)
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000030);
		host.launch(2'b01, 1'b1);
		`CHK(n_st[0] - s0, 1)
		bus(1'b1, hthf_pkg::REG_TASKCFG, {26'h0, hthf_pkg::TC_BOOT, hthf_pkg::TC_IT});
		host.launch(2'b11, 1'b0);
		`CHK(n_st[0] - s0, 2)
		`CHK(n_st[1] - s1, 1)
		bus(1'b1, hthf_pkg::REG_CTRL, 32'h00000010);
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000010);
		host.launch(2'b01, 1'b0);
		`CHK(n_st[0] - s0, 2)
		bus(1'b1, hthf_pkg::REG_CTRL, 32'h00000000);
	endtask : t_launch
	task automatic t_prog_err;
		int e, s0;
		bus(1'b1, hthf_pkg::REG_ERRINFO, 32'h00420123);
		e = eb_n;
		s0 = n_st[0];
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000002);
		tick(2);
		`CHK(program_error_flag, 1'b1)
		`CHK(fault_lamp, 1'b1)
		`CHK(access_permitted_flag, 1'b0)
		`CHK(eb_n - e, 2)
		`CHK({eb_a[e % 4], eb_d[e % 4]}, 32'h24000123)
		`CHK({eb_a[(e + 1) % 4], eb_d[(e + 1) % 4]}, 32'h24010042)
		host.launch(2'b01, 1'b0);
		`CHK(n_st[0] - s0, 0)
	endtask : t_prog_err
	task automatic t_mod_reset;
		int u, l0, l1;
		bus(1'b1, hthf_pkg::REG_TASKCFG, {26'h0, hthf_pkg::TC_OFF, hthf_pkg::TC_BOOT});
		u = n_ud;
		l0 = n_ld[0];
		l1 = n_ld[1];
		host.reset_req();
		host.rw_cmd();
		`CHK(module_alive_flag, 1'b1)
		`CHK(n_ud - u, 0)
		wait_alive(1'b0);
		`CHK(module_reset_active, 1'b1)
		`CHK(access_permitted_flag, 1'b0)
		wait_alive(1'b1);
		`CHK(n_ld[0] - l0, 1)
		`CHK(n_ld[1] - l1, 0)
		`CHK(access_permitted_flag, 1'b0)
		host.rw_cmd();
		`CHK(n_ud - u, 1)
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000001);
		tick(3);
		`CHK(access_permitted_flag, 1'b1)
	endtask : t_mod_reset
	task automatic t_sys_fail;
		int e;
		bus(1'b1, hthf_pkg::REG_ERRINFO, 32'h00770000);
		e = eb_n;
		bus(1'b1, hthf_pkg::REG_EVENT, 32'h00000004);
		tick(2);
		`CHK(system_failure_flag, 1'b1)
		`CHK(fault_lamp, 1'b1)
		`CHK(access_permitted_flag, 1'b0)
		`CHK(eb_n - e, 1)
		`CHK({eb_a[e % 4], eb_d[e % 4]}, 32'h24000077)
		mode_switch <= 4'h2;
		tick(6);
		`CHK(system_failure_flag, 1'b0)
		mode_switch <= 4'h1;
		tick(6);
		`CHK(system_failure_flag, 1'b1)
	endtask : t_sys_fail
	////////////////////////////////////////
	// main sequence
	initial
	begin
		reset = 1'b1;
		{read, write, address, writedata} = '0;
		mode_switch = 4'h0;
		tick(2);
		reset <= 1'b0;
		t_boot();
		t_gp();
		t_launch();
		t_prog_err();
		t_mod_reset();
		t_sys_fail();
		finish_test();
	end
endmodule : tb_host_task_handshake_flags
`default_nettype wire
